// File: logic/wgcz_pkg.sv
// Constants for the waveform generator control register bank
package wgcz_pkg;
  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [31:0] WGCZ_CTRL0_OFFSET   = 32'h0000_0000;
  localparam logic [7:0]  WGCZ_CTRL0_RESET    = 8'h00;
  localparam logic [7:0]  WGCZ_CTRL0_WR_MASK  = 8'hf9;
  localparam int          WGCZ_BIT_ENABLE     = 7;
  localparam int          WGCZ_BIT_OE_B       = 6;
  localparam int          WGCZ_BIT_OE_A       = 5;
  localparam int          WGCZ_BIT_INV_B      = 4;
  localparam int          WGCZ_BIT_INV_A      = 3;
  localparam int          WGCZ_BIT_CLK_SEL    = 0;
  localparam int          WGCZ_ADDR_LSB       = 2;
  localparam int          WGCZ_ADDR_W         = 12;

  // ****************************************
  // Bus response codes
  // ****************************************
  localparam logic [1:0]  WGCZ_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  WGCZ_RESP_SLVERR    = 2'h2;
  localparam logic [31:0] WGCZ_RDATA_ZERO     = 32'h0000_0000;
endpackage

// File: logic/wgcz_ctl_if.sv
// Control fields and pin signals between register bank and output stage
`timescale 1ns/10ps
interface wgcz_ctl_if;
  logic enable;
  logic oe_a;
  logic oe_b;
  logic inv_a;
  logic inv_b;
  logic clk_sel;
  logic raw_a;
  logic raw_b;
  logic osc_tick;
  logic pin_a;
  logic pin_a_oe;
  logic pin_b;
  logic pin_b_oe;
  logic gen_tick;

  modport bank  (output enable, oe_a, oe_b, inv_a, inv_b, clk_sel, raw_a, raw_b, osc_tick,
                 input  pin_a, pin_a_oe, pin_b, pin_b_oe, gen_tick);
  modport stage (input  enable, oe_a, oe_b, inv_a, inv_b, clk_sel, raw_a, raw_b, osc_tick,
                 output pin_a, pin_a_oe, pin_b, pin_b_oe, gen_tick);
endinterface

// File: logic/wgcz_out_stage.sv
// Output stage: gates, inverts and registers the complementary outputs
`timescale 1ns/10ps
module wgcz_out_stage
  import wgcz_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  wgcz_ctl_if.stage   ctl
);

  // Pin level: generator wave gated by enable, then polarity applied
  function automatic logic pin_level(input logic raw, input logic en, input logic inv);
    pin_level = (raw & en) ^ inv;
  endfunction

  logic pin_a_ff;
  logic pin_a_oe_ff;
  logic pin_b_ff;
  logic pin_b_oe_ff;
  logic gen_tick_ff;
  wire  nxt_pin_a    = pin_level(ctl.raw_a, ctl.enable, ctl.inv_a);
  wire  nxt_pin_b    = pin_level(ctl.raw_b, ctl.enable, ctl.inv_b);
  wire  nxt_gen_tick = ctl.enable & (ctl.clk_sel ? ctl.osc_tick : 1'b1);

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_a_ff    <= 1'b0;
      pin_a_oe_ff <= 1'b0;
      pin_b_ff    <= 1'b0;
      pin_b_oe_ff <= 1'b0;
      gen_tick_ff <= 1'b0;
    end else begin
      pin_a_ff    <= nxt_pin_a;
      pin_a_oe_ff <= ctl.oe_a;
      pin_b_ff    <= nxt_pin_b;
      pin_b_oe_ff <= ctl.oe_b;
      gen_tick_ff <= nxt_gen_tick;
    end
  end

  assign ctl.pin_a    = pin_a_ff;
  assign ctl.pin_a_oe = pin_a_oe_ff;
  assign ctl.pin_b    = pin_b_ff;
  assign ctl.pin_b_oe = pin_b_oe_ff;
  assign ctl.gen_tick = gen_tick_ff;

  // ****************************************
  // Checks
  // ****************************************
  property p_oe_b_follows;
    @(posedge clk) disable iff (rst) 1'b1 |=> (ctl.pin_b_oe == $past(ctl.oe_b));
  endproperty
  a_oe_b_follows: assert property (p_oe_b_follows) else $error("B enable not on pin");

  property p_oe_a_follows;
    @(posedge clk) disable iff (rst) 1'b1 |=> (ctl.pin_a_oe == $past(ctl.oe_a));
  endproperty
  a_oe_a_follows: assert property (p_oe_a_follows) else $error("A enable not on pin");

  property p_polarity;
    @(posedge clk) disable iff (rst)
      !ctl.enable ##1 1'b1 |-> (ctl.pin_a == $past(ctl.inv_a)) && (ctl.pin_b == $past(ctl.inv_b));
  endproperty
  a_polarity: assert property (p_polarity) else $error("Idle level ignores polarity");

  property p_disabled_idle;
    @(posedge clk) disable iff (rst) !ctl.enable |=> !ctl.gen_tick;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("Generator runs disabled");

  property p_clk_source;
    @(posedge clk) disable iff (rst)
      ctl.enable |=> (ctl.gen_tick == ($past(ctl.clk_sel) ? $past(ctl.osc_tick) : 1'b1));
  endproperty
  a_clk_source: assert property (p_clk_source) else $error("Wrong generator clock");

endmodule

// File: logic/wgcz_top.sv
// Waveform generator control register zero with an AXI4-Lite slave
`timescale 1ns/10ps
module wgcz_top
  import wgcz_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        gen_wave_a,
  input  wire logic        gen_wave_b,
  input  wire logic        internal_fast_oscillator,
  output logic             complementary_out_a,
  output logic             complementary_out_a_oe,
  output logic             complementary_out_b,
  output logic             complementary_out_b_oe,
  output logic             gen_clock_tick
);

  // Address match against the single implemented register
  function automatic logic addr_hit(input logic [31:0] addr);
    addr_hit = (addr[WGCZ_ADDR_W-1:WGCZ_ADDR_LSB]
                == WGCZ_CTRL0_OFFSET[WGCZ_ADDR_W-1:WGCZ_ADDR_LSB]);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  ctrl0_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  // ****************************************
  // Write channel decode
  // ****************************************
  wire        aw_take    = s_axi_awvalid & awready_ff;
  wire        w_take     = s_axi_wvalid & wready_ff;
  wire        do_write   = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire        wr_hit     = addr_hit(awaddr_ff);
  wire        wr_lane0   = wstrb_ff[0];
  wire [7:0]  wr_value   = wdata_ff[7:0] & WGCZ_CTRL0_WR_MASK;
  wire        nxt_aw_got = do_write ? 1'b0 : (aw_got_ff | aw_take);
  wire        nxt_w_got  = do_write ? 1'b0 : (w_got_ff | w_take);
  wire        nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);
  wire [7:0]  nxt_ctrl0  = (do_write & wr_hit & wr_lane0) ? wr_value : ctrl0_ff;

  // ****************************************
  // Read channel decode
  // ****************************************
  wire        ar_take    = s_axi_arvalid & arready_ff;
  wire        rd_hit     = addr_hit(s_axi_araddr);
  wire        nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
  wire [31:0] rd_value   = {24'h00_0000, ctrl0_ff & WGCZ_CTRL0_WR_MASK};

  // Control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0_ff <= WGCZ_CTRL0_RESET;
    end else begin
      ctrl0_ff <= nxt_ctrl0;
    end
  end

  // Write address and data capture
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 32'h0000_0000;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awaddr_ff  <= aw_take ? s_axi_awaddr : awaddr_ff;
      wdata_ff   <= w_take ? s_axi_wdata : wdata_ff;
      wstrb_ff   <= w_take ? s_axi_wstrb : wstrb_ff;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= WGCZ_RESP_OKAY;
    end else begin
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= do_write ? (wr_hit ? WGCZ_RESP_OKAY : WGCZ_RESP_SLVERR) : bresp_ff;
    end
  end

  // Read address and data
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= WGCZ_RDATA_ZERO;
      rresp_ff   <= WGCZ_RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= ar_take ? (rd_hit ? rd_value : WGCZ_RDATA_ZERO) : rdata_ff;
      rresp_ff   <= ar_take ? (rd_hit ? WGCZ_RESP_OKAY : WGCZ_RESP_SLVERR) : rresp_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // ****************************************
  // Output stage
  // ****************************************
  wgcz_ctl_if ctl ();

  // Register fields steer the output stage
  assign ctl.enable   = ctrl0_ff[WGCZ_BIT_ENABLE];
  assign ctl.oe_b     = ctrl0_ff[WGCZ_BIT_OE_B];
  assign ctl.oe_a     = ctrl0_ff[WGCZ_BIT_OE_A];
  assign ctl.inv_b    = ctrl0_ff[WGCZ_BIT_INV_B];
  assign ctl.inv_a    = ctrl0_ff[WGCZ_BIT_INV_A];
  assign ctl.clk_sel  = ctrl0_ff[WGCZ_BIT_CLK_SEL];
  assign ctl.raw_a    = gen_wave_a;
  assign ctl.raw_b    = gen_wave_b;
  assign ctl.osc_tick = internal_fast_oscillator;

  wgcz_out_stage u_out_stage (
    .clk (clk),
    .rst (rst),
    .ctl (ctl.stage)
  );

  assign complementary_out_a    = ctl.pin_a;
  assign complementary_out_a_oe = ctl.pin_a_oe;
  assign complementary_out_b    = ctl.pin_b;
  assign complementary_out_b_oe = ctl.pin_b_oe;
  assign gen_clock_tick         = ctl.gen_tick;

  // ****************************************
  // Checks
  // ****************************************
  property p_enable_write;
    @(posedge clk) disable iff (rst)
      do_write && wr_hit && wr_lane0 |=> ##1
        ((gen_clock_tick == 1'b0) == !$past(wr_value[WGCZ_BIT_ENABLE], 2))
        || $past(wr_value[WGCZ_BIT_CLK_SEL], 2);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("Enable write not applied");

  property p_oe_pin_delay;
    @(posedge clk) disable iff (rst)
      do_write && wr_hit && wr_lane0 |=> ##1
        (complementary_out_b_oe == $past(wr_value[WGCZ_BIT_OE_B], 2))
        && (complementary_out_a_oe == $past(wr_value[WGCZ_BIT_OE_A], 2));
  endproperty
  a_oe_pin_delay: assert property (p_oe_pin_delay) else $error("Pin enables late");

  property p_inv_store;
    @(posedge clk) disable iff (rst)
      do_write && wr_hit && wr_lane0 |=> (ctl.inv_b == $past(wdata_ff[WGCZ_BIT_INV_B]))
        && (ctl.inv_a == $past(wdata_ff[WGCZ_BIT_INV_A]));
  endproperty
  a_inv_store: assert property (p_inv_store) else $error("Polarity bits not stored");

  property p_unimpl_zero;
    @(posedge clk) disable iff (rst)
      rvalid_ff |-> ((s_axi_rdata & ~{24'h00_0000, WGCZ_CTRL0_WR_MASK}) == WGCZ_RDATA_ZERO);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("Bits 2..1 read nonzero");

  // Read data returns the stored register value
  property p_read_value;
    @(posedge clk) disable iff (rst)
      ar_take && rd_hit |=> (s_axi_rdata == {24'h00_0000, $past(ctrl0_ff)});
  endproperty
  a_read_value: assert property (p_read_value) else $error("Read data not the register");

  property p_bresp_timing;
    @(posedge clk) disable iff (rst) aw_got_ff && w_got_ff && !bvalid_ff |=> bvalid_ff;
  endproperty
  a_bresp_timing: assert property (p_bresp_timing) else $error("Write response late");

  c_write_ctrl: cover property (@(posedge clk) disable iff (rst) do_write && wr_hit);
  c_read_ctrl:  cover property (@(posedge clk) disable iff (rst) ar_take && rd_hit);
  c_bad_addr:   cover property (@(posedge clk) disable iff (rst) do_write && !wr_hit);
  c_osc_run:    cover property (@(posedge clk) disable iff (rst) ctl.enable && ctl.clk_sel);

endmodule

// File: test/tb_top.sv
// Self-checking bench for the waveform generator control register
`timescale 1ns/10ps
module tb_top
  import wgcz_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        wave_a = 1'b0, wave_b = 1'b0, osc = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        out_a, oe_a, out_b, oe_b, tick;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, data;
  int          num_errors = 0;
  int          check_count = 0;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  wgcz_top wgcz_top_inst (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gen_wave_a(wave_a), .gen_wave_b(wave_b), .internal_fast_oscillator(osc),
    .complementary_out_a(out_a), .complementary_out_a_oe(oe_a),
    .complementary_out_b(out_b), .complementary_out_b_oe(oe_b), .gen_clock_tick(tick)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bus write: both channels offered together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  // Bus read: address held until taken, data taken when valid
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(WGCZ_CTRL0_OFFSET, data, resp);
    chk("reset value", 32'h0, data);
    chk("reset resp", {30'h0, WGCZ_RESP_OKAY}, {30'h0, resp});
    chk("reset pins", 32'h0, {27'h0, out_a, oe_a, out_b, oe_b, tick});
    $display("Test reset done");
  endtask

  task automatic t_fields;
    wr(WGCZ_CTRL0_OFFSET, 32'hffff_ffff, 4'hf, resp);
    chk("all ones write resp", {30'h0, WGCZ_RESP_OKAY}, {30'h0, resp});
    rd(WGCZ_CTRL0_OFFSET, data, resp);
    chk("all ones readback", 32'h0000_00f9, data);
    wr(WGCZ_CTRL0_OFFSET, 32'h0000_0000, 4'he, resp);
    chk("lane zero off resp", {30'h0, WGCZ_RESP_OKAY}, {30'h0, resp});
    rd(WGCZ_CTRL0_OFFSET, data, resp);
    chk("lane zero off", 32'h0000_00f9, data);
    wr(WGCZ_CTRL0_OFFSET, 32'h0000_0006, 4'hf, resp);
    chk("unused bits resp", {30'h0, WGCZ_RESP_OKAY}, {30'h0, resp});
    rd(WGCZ_CTRL0_OFFSET, data, resp);
    chk("unused bits", 32'h0, data);
    wr(32'h0000_0004, 32'h0000_0080, 4'hf, resp);
    chk("unmapped write resp", {30'h0, WGCZ_RESP_SLVERR}, {30'h0, resp});
    rd(32'h0000_0004, data, resp);
    chk("unmapped read resp", {30'h0, WGCZ_RESP_SLVERR}, {30'h0, resp});
    chk("unmapped read data", WGCZ_RDATA_ZERO, data);
    rd(WGCZ_CTRL0_OFFSET, data, resp);
    chk("after unmapped", 32'h0, data);
    $display("Test fields done");
  endtask

  // Every enable, output enable and invert setting against every wave pair
  task automatic t_pins;
    logic [4:0] k;
    for (int i = 0; i < 32; i++) begin
      k = i[4:0];
      wr(WGCZ_CTRL0_OFFSET, {24'h0, k, 3'b000}, 4'h1, resp);
      for (int w = 0; w < 4; w++) begin
        wave_a <= w[0];
        wave_b <= w[1];
        repeat (3) @(posedge clk);
        chk("oe a", {31'h0, k[2]}, {31'h0, oe_a});
        chk("oe b", {31'h0, k[3]}, {31'h0, oe_b});
        chk("out a", {31'h0, (w[0] & k[4]) ^ k[0]}, {31'h0, out_a});
        chk("out b", {31'h0, (w[1] & k[4]) ^ k[1]}, {31'h0, out_b});
      end
    end
    $display("Test pins done");
  endtask

  // Generator clock: system clock, fast oscillator pulses, disabled
  task automatic t_clock;
    logic [7:0] cfg [3] = '{8'h80, 8'h81, 8'h01};
    int         exp [3] = '{24, 4, 0};
    int         cnt;
    for (int c = 0; c < 3; c++) begin
      wr(WGCZ_CTRL0_OFFSET, {24'h0, cfg[c]}, 4'h1, resp);
      repeat (2) @(posedge clk);
      cnt = 0;
      for (int i = 0; i < 24; i++) begin
        @(posedge clk);
        if (tick === 1'b1) cnt++;
        osc <= (i < 20 && i % 5 == 0);
      end
      chk("tick count", exp[c], cnt);
    end
    $display("Test clock done");
  endtask

  // Reset in mid-run clears the register and every pin
  task automatic t_midreset;
    wr(WGCZ_CTRL0_OFFSET, 32'h0000_00f9, 4'h1, resp);
    chk("pre reset resp", {30'h0, WGCZ_RESP_OKAY}, {30'h0, resp});
    repeat (3) @(posedge clk);
    chk("pre reset enables", 32'h3, {30'h0, oe_b, oe_a});
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pins after reset", 32'h0, {27'h0, out_a, oe_a, out_b, oe_b, tick});
    rd(WGCZ_CTRL0_OFFSET, data, resp);
    chk("value after reset", {24'h0, WGCZ_CTRL0_RESET}, data);
    $display("Test mid reset done");
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_fields();
    t_pins();
    t_clock();
    t_midreset();
    stop_test();
  end
endmodule
